//--- design/tlr_defs.svh
// Pointer offsets, field positions, reset values and sizes of the limit and result registers.
`ifndef TLR_DEFS_SVH
`define TLR_DEFS_SVH

// Pointer addresses.
`define TLR_PTR_LOCAL_HI    8'h00
`define TLR_PTR_RLL_FRAC    8'h14
`define TLR_PTR_LOCAL_FRAC  8'h15
`define TLR_PTR_REMOTE_CRIT 8'h19
`define TLR_PTR_LOCAL_CRIT  8'h20
`define TLR_PTR_CRIT_HYST   8'h21
`define TLR_PTR_ALERT_CFG   8'h22

// Reset values.
`define TLR_RST_RLL_FRAC    4'h0
`define TLR_RST_REMOTE_CRIT 8'h6c
`define TLR_RST_LOCAL_CRIT  8'h55
`define TLR_RST_CRIT_HYST   8'h0a
`define TLR_RST_CODE        3'h0
`define TLR_RST_TIMEOUT     1'b0
`define TLR_RST_CFG_RSV0    1'b1

// Field positions of the alert configuration register.
`define TLR_CFG_TIMEOUT_BIT 7
`define TLR_CFG_CODE_HI     3
`define TLR_CFG_CODE_LO     1

// Width of a temperature word: eight integer bits and four fraction bits.
`define TLR_TEMP_W          12
`define TLR_FRAC_W          4

`endif

//--- design/tlr_pkg.sv
// Types and helper functions shared by the limit and result register bank.
`default_nettype none
package tlr_pkg;

  // One pointer access from the serial interface, valid for one cycle.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] ptr;
    logic [7:0] wdata;
  } tlr_req_t;

  // Coherency lock state of the local result byte pair.
  typedef enum logic [2:0] {
    TLR_OPEN    = 3'b001,
    TLR_LO_HELD = 3'b010,
    TLR_HI_HELD = 3'b100
  } tlr_lock_t;

  // Consecutive measurements needed: one plus the number of set code bits.
  function automatic logic [2:0] tlr_need(input logic [2:0] code);
    tlr_need = 3'h1 + {2'h0, code[0]} + {2'h0, code[1]} + {2'h0, code[2]};
  endfunction : tlr_need

  // Release point of a critical limit; saturates at zero.
  function automatic logic [7:0] tlr_sat_sub(input logic [7:0] a, input logic [7:0] b);
    tlr_sat_sub = (a > b) ? (a - b) : 8'h00;
  endfunction : tlr_sat_sub

endpackage : tlr_pkg
`default_nettype wire

//--- design/tlr_crit_cmp.sv
// Critical temperature comparator with hysteresis, sampled once per conversion.
`default_nettype none
module tlr_crit_cmp
  import tlr_pkg::*;
#(
  parameter int BYTE_W = 8
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // Measurement and limits.
  input  wire logic              sample_i,
  input  wire logic [BYTE_W-1:0] temp_i,
  input  wire logic [BYTE_W-1:0] limit_i,
  input  wire logic [BYTE_W-1:0] hyst_i,
  // Comparator state.
  output logic                   hot_o
);

  // Only eight-bit limits are served; any other width is refused at elaboration.
  if (BYTE_W != 8) begin : g_bad_width
    $error("tlr_crit_cmp serves only eight-bit limits");
  end

  // Release point and next state; reaching the limit always sets, even with zero hysteresis.
  wire logic [7:0] release_pt = tlr_sat_sub(limit_i, hyst_i);
  wire logic       next_hot   = (temp_i >= limit_i) || (hot_o && (temp_i > release_pt));

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hot_o <= 1'b0;
    end else if (sample_i) begin
      hot_o <= next_hot;
    end
  end

  property p_crit_set;
    @(posedge clk_i) disable iff (srst_i)
      (sample_i && temp_i >= limit_i) |=> hot_o;
  endproperty
  a_crit_set: assert property (p_crit_set) else $error("critical not set at limit");

  property p_crit_hold;
    @(posedge clk_i) disable iff (srst_i)
      (sample_i && hot_o && temp_i > tlr_sat_sub(limit_i, hyst_i)) |=> hot_o;
  endproperty
  a_crit_hold: assert property (p_crit_hold) else $error("critical released early");

endmodule : tlr_crit_cmp
`default_nettype wire

//--- design/tlr_pair_lock.sv
// Local result byte pair with the read coherency lock.
`default_nettype none
`include "tlr_defs.svh"
module tlr_pair_lock
  import tlr_pkg::*;
#(
  parameter int TEMP_W = `TLR_TEMP_W
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // Converter side.
  input  wire logic              conv_i,
  input  wire logic [TEMP_W-1:0] temp_i,
  // Host access.
  input  wire tlr_req_t          req_i,
  // Stored bytes and lock state.
  output logic [7:0]             hi_o,
  output logic [3:0]             lo_o,
  output tlr_lock_t              state_o
);

  // Only twelve-bit results are served; any other width is refused at elaboration.
  if (TEMP_W != 12) begin : g_bad_width
    $error("tlr_pair_lock serves only twelve-bit results");
  end

  // Decode of the access that steers the lock.
  wire logic any_acc = req_i.rd | req_i.wr;
  wire logic hi_rd   = req_i.rd && (req_i.ptr == `TLR_PTR_LOCAL_HI);
  wire logic lo_rd   = req_i.rd && (req_i.ptr == `TLR_PTR_LOCAL_FRAC);
  tlr_lock_t next_state;

  // first read of either byte locks the other. read of the held byte or any other access frees.
  always_comb begin
    next_state = state_o;
    if (hi_rd) begin
      next_state = (state_o == TLR_HI_HELD) ? TLR_OPEN : TLR_LO_HELD;
    end else if (lo_rd) begin
      next_state = (state_o == TLR_LO_HELD) ? TLR_OPEN : TLR_HI_HELD;
    end else if (any_acc) begin
      next_state = TLR_OPEN;
    end
  end

  // converter refresh, unless the byte is held by the next state.
  wire logic hi_upd = conv_i && (next_state != TLR_HI_HELD);
  wire logic lo_upd = conv_i && (next_state != TLR_LO_HELD);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_o <= TLR_OPEN;
      hi_o    <= 8'h00;
      lo_o    <= 4'h0;
    end else begin
      state_o <= next_state;
      if (hi_upd) begin
        hi_o <= temp_i[TEMP_W-1:4];
      end
      if (lo_upd) begin
        lo_o <= temp_i[3:0];
      end
    end
  end

  property p_lo_frozen;
    @(posedge clk_i) disable iff (srst_i)
      (state_o == TLR_LO_HELD && (!any_acc || hi_rd)) |=> $stable(lo_o);
  endproperty
  a_lo_frozen: assert property (p_lo_frozen) else $error("low byte moved while held");

  property p_hi_frozen;
    @(posedge clk_i) disable iff (srst_i)
      (state_o == TLR_HI_HELD && (!any_acc || lo_rd)) |=> $stable(hi_o);
  endproperty
  a_hi_frozen: assert property (p_hi_frozen) else $error("high byte moved while held");

  property p_release;
    @(posedge clk_i) disable iff (srst_i)
      (any_acc && !hi_rd && !lo_rd) |=> (state_o == TLR_OPEN);
  endproperty
  a_release: assert property (p_release) else $error("lock kept after other access");

endmodule : tlr_pair_lock
`default_nettype wire

//--- design/tlr_regs.sv
// Limit, hysteresis, alert configuration and local result registers of the monitor.
//
// Contract
// - Remote low limit fraction in bits 7-4.
// - Local fraction bits 7-4, low bits zero.
// - Local fraction register read-only, resets zero.
// - Result bytes refresh each conversion unless held.
// - High byte read first holds low byte.
// - Low byte read first holds high byte.
// - Any other access releases the hold.
// - Remote critical limit, read-write, resets 6Ch.
// - Local critical limit, read-write, one degree steps.
// - Critical hysteresis, read-write, resets 0Ah.
// - Alert config: timeout bit 7, count 3-1.
// - Timeout bit enables bus timeout behaviour.
// - Count code sets consecutive measurements needed.
`default_nettype none
`include "tlr_defs.svh"
module tlr_regs
  import tlr_pkg::*;
#(
  parameter int TEMP_W = `TLR_TEMP_W
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // Pointer access from the serial interface.
  input  wire tlr_req_t          req_i,
  output logic [7:0]             rdata_o,
  // Converter results and the remote low limit integer byte.
  input  wire logic              conv_done_i,
  input  wire logic [TEMP_W-1:0] local_temp_i,
  input  wire logic [TEMP_W-1:0] remote_temp_i,
  input  wire logic [7:0]        remote_low_limit_int_i,
  // Status and control outputs.
  output logic                   critical_temp_output_o,
  output logic                   remote_low_alert_o,
  output logic                   bus_timeout_enable_o,
  output logic [2:0]             consecutive_count_code_o
);

  // Only twelve-bit results are served; any other width is refused at elaboration.
  if (TEMP_W != 12) begin : g_bad_width
    $error("tlr_regs serves only twelve-bit results");
  end

  // Stored control fields; reserved bits have no storage at all.
  logic [3:0] remote_low_limit_frac_bits;
  logic [7:0] remote_critical_limit_bits;
  logic [7:0] local_critical_limit_bits;
  logic [7:0] critical_hysteresis_bits;
  logic [2:0] consec_cnt;

  // Outputs of the lock and the comparators.
  logic [7:0] local_hi;
  logic [3:0] local_temp_frac_bits;
  tlr_lock_t  lock_state;
  logic       local_hot;
  logic       remote_hot;

  // Write decode; the local result pointers have no write strobe.
  wire logic wr_rll  = req_i.wr && (req_i.ptr == `TLR_PTR_RLL_FRAC);
  wire logic wr_rcl  = req_i.wr && (req_i.ptr == `TLR_PTR_REMOTE_CRIT);
  wire logic wr_lcl  = req_i.wr && (req_i.ptr == `TLR_PTR_LOCAL_CRIT);
  wire logic wr_hys  = req_i.wr && (req_i.ptr == `TLR_PTR_CRIT_HYST);
  wire logic wr_cfg  = req_i.wr && (req_i.ptr == `TLR_PTR_ALERT_CFG);

  // register image; reserved bits read back their reset values.
  wire logic [7:0] cfg_image = {bus_timeout_enable_o, 3'h0,
                                consecutive_count_code_o, `TLR_RST_CFG_RSV0};

  // Read selection. low fraction nibble reads zero. Unmapped pointers read zero.
  wire logic [7:0] next_rdata =
    (req_i.ptr == `TLR_PTR_LOCAL_HI)    ? local_hi :
    (req_i.ptr == `TLR_PTR_LOCAL_FRAC)  ? {local_temp_frac_bits, 4'h0} :
    (req_i.ptr == `TLR_PTR_RLL_FRAC)    ? {remote_low_limit_frac_bits, 4'h0} :
    (req_i.ptr == `TLR_PTR_REMOTE_CRIT) ? remote_critical_limit_bits :
    (req_i.ptr == `TLR_PTR_LOCAL_CRIT)  ? local_critical_limit_bits :
    (req_i.ptr == `TLR_PTR_CRIT_HYST)   ? critical_hysteresis_bits :
    (req_i.ptr == `TLR_PTR_ALERT_CFG)   ? cfg_image : 8'h00;

  // Read data is captured at the access edge and held until the next read.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      remote_critical_limit_bits <= `TLR_RST_REMOTE_CRIT;
      local_critical_limit_bits  <= `TLR_RST_LOCAL_CRIT;
      critical_hysteresis_bits   <= `TLR_RST_CRIT_HYST;
    end else begin
      if (wr_rcl) begin
        remote_critical_limit_bits <= req_i.wdata;
      end
      if (wr_lcl) begin
        local_critical_limit_bits <= req_i.wdata;
      end
      if (wr_hys) begin
        critical_hysteresis_bits <= req_i.wdata;
      end
    end
  end

  // fraction storage; written reserved bits are dropped.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      remote_low_limit_frac_bits <= `TLR_RST_RLL_FRAC;
    end else if (wr_rll) begin
      remote_low_limit_frac_bits <= req_i.wdata[7:4];
    end
  end

  // configuration fields; the timeout enable leaves as a level.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bus_timeout_enable_o     <= `TLR_RST_TIMEOUT;
      consecutive_count_code_o <= `TLR_RST_CODE;
    end else if (wr_cfg) begin
      bus_timeout_enable_o     <= req_i.wdata[`TLR_CFG_TIMEOUT_BIT];
      consecutive_count_code_o <= req_i.wdata[`TLR_CFG_CODE_HI:`TLR_CFG_CODE_LO];
    end
  end

  // local result pair, refreshed by the converter only.
  tlr_pair_lock #(
    .TEMP_W (TEMP_W)
  ) u_lock (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .conv_i  (conv_done_i),
    .temp_i  (local_temp_i),
    .req_i   (req_i),
    .hi_o    (local_hi),
    .lo_o    (local_temp_frac_bits),
    .state_o (lock_state)
  );

  // one comparator per channel, both sharing the hysteresis.
  tlr_crit_cmp #(
    .BYTE_W (8)
  ) u_local_crit (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sample_i (conv_done_i),
    .temp_i   (local_temp_i[TEMP_W-1:4]),
    .limit_i  (local_critical_limit_bits),
    .hyst_i   (critical_hysteresis_bits),
    .hot_o    (local_hot)
  );

  tlr_crit_cmp #(
    .BYTE_W (8)
  ) u_remote_crit (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sample_i (conv_done_i),
    .temp_i   (remote_temp_i[TEMP_W-1:4]),
    .limit_i  (remote_critical_limit_bits),
    .hyst_i   (critical_hysteresis_bits),
    .hot_o    (remote_hot)
  );

  // one pin for both channels; registered so the pin never glitches.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      critical_temp_output_o <= 1'b0;
    end else begin
      critical_temp_output_o <= local_hot | remote_hot;
    end
  end

  // remote reading compared against the combined low limit.
  wire logic [TEMP_W-1:0] low_limit  = {remote_low_limit_int_i, remote_low_limit_frac_bits};
  wire logic              below      = remote_temp_i < low_limit;
  wire logic [2:0]        need       = tlr_need(consecutive_count_code_o);
  wire logic [2:0]        next_cnt   = !below ? 3'h0 :
                                       (consec_cnt >= need) ? consec_cnt : consec_cnt + 3'h1;

  // run of out-of-limit conversions; one good reading clears it.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      consec_cnt         <= 3'h0;
      remote_low_alert_o <= 1'b0;
    end else if (conv_done_i) begin
      consec_cnt         <= next_cnt;
      remote_low_alert_o <= (next_cnt >= need);
    end
  end

  // Checks on the register image, the result refresh, the critical pin and the alert run.
  property p_ro_frac;
    @(posedge clk_i) disable iff (srst_i)
      (req_i.wr && req_i.ptr == `TLR_PTR_LOCAL_FRAC && !conv_done_i)
        |=> $stable(local_temp_frac_bits);
  endproperty
  a_ro_frac: assert property (p_ro_frac) else $error("write reached read-only byte");

  property p_frac_zero;
    @(posedge clk_i) disable iff (srst_i)
      (req_i.rd && req_i.ptr == `TLR_PTR_LOCAL_FRAC) |=> (rdata_o[3:0] == 4'h0);
  endproperty
  a_frac_zero: assert property (p_frac_zero) else $error("fraction low nibble not zero");

  property p_cfg_rsv;
    @(posedge clk_i) disable iff (srst_i)
      (req_i.rd && req_i.ptr == `TLR_PTR_ALERT_CFG)
        |=> (rdata_o[6:4] == 3'h0 && rdata_o[0] == 1'b1);
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("reserved config bits wrong");

  property p_rcl_back;
    @(posedge clk_i) disable iff (srst_i)
      (wr_rcl ##1 (req_i.rd && req_i.ptr == `TLR_PTR_REMOTE_CRIT && !req_i.wr))
        |=> (rdata_o == $past(req_i.wdata, 2));
  endproperty
  a_rcl_back: assert property (p_rcl_back) else $error("remote limit readback wrong");

  property p_timeout;
    @(posedge clk_i) disable iff (srst_i)
      wr_cfg |=> (bus_timeout_enable_o == $past(req_i.wdata[7]));
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout enable not taken");

  property p_refresh;
    @(posedge clk_i) disable iff (srst_i)
      (conv_done_i && lock_state == TLR_OPEN && !req_i.rd && !req_i.wr)
        |=> (local_hi == $past(local_temp_i[11:4]));
  endproperty
  a_refresh: assert property (p_refresh) else $error("result byte not refreshed");

  property p_alert_one;
    @(posedge clk_i) disable iff (srst_i)
      (conv_done_i && below && consecutive_count_code_o == 3'h0) |=> remote_low_alert_o;
  endproperty
  a_alert_one: assert property (p_alert_one) else $error("single-sample alert missing");

  property p_alert_good;
    @(posedge clk_i) disable iff (srst_i)
      (conv_done_i && !below) |=> !remote_low_alert_o;
  endproperty
  a_alert_good: assert property (p_alert_good) else $error("alert kept on good reading");

  property p_pin;
    @(posedge clk_i) disable iff (srst_i)
      (local_hot || remote_hot) |=> critical_temp_output_o;
  endproperty
  a_pin: assert property (p_pin) else $error("critical pin not driven");

  // Main scenarios.
  c_pair_read: cover property (@(posedge clk_i) disable iff (srst_i)
    (req_i.rd && req_i.ptr == `TLR_PTR_LOCAL_HI) ##1
    (req_i.rd && req_i.ptr == `TLR_PTR_LOCAL_FRAC));
  c_crit: cover property (@(posedge clk_i) disable iff (srst_i)
    $rose(critical_temp_output_o));
  c_alert4: cover property (@(posedge clk_i) disable iff (srst_i)
    $rose(remote_low_alert_o) && consecutive_count_code_o == 3'h7);

endmodule : tlr_regs
`default_nettype wire

//--- bench/tlr_host_model.sv
// Host-side access model that turns one bench command into a single-cycle register strobe.
`default_nettype none
module tlr_host_model
  import tlr_pkg::*;
(
  // Clock.
  input  wire logic     clk_i,
  // Command from the bench.
  input  wire logic     go_i,
  input  wire tlr_req_t op_i,
  // Strobe to the register bank and its completion.
  output tlr_req_t      req_o = '0,
  output logic          done_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // The strobe lasts one cycle. An idle pointer and data show the inverse of the last value,
  // so a stale address can never pass for a live one.
  always_ff @(posedge clk_i) begin
    req_o  <= '{rd: 1'b0, wr: 1'b0, ptr: ~req_o.ptr, wdata: ~req_o.wdata};
    done_o <= req_o.rd | req_o.wr;
    if (go_i) begin
      req_o <= op_i;
    end
  end

endmodule : tlr_host_model
`default_nettype wire

//--- bench/tlr_regs_bench.sv
// Self-checking bench for the limit and result register bank.
`default_nettype none
`include "tlr_defs.svh"
module tlr_regs_bench
  import tlr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Bench-driven signals.
  logic        clk_i       = 1'b0;
  logic        srst_i      = 1'b1;
  logic        go          = 1'b0;
  tlr_req_t    op          = '0;
  logic        conv_done   = 1'b0;
  logic [11:0] local_temp  = 12'h000;
  logic [11:0] remote_temp = 12'h000;
  logic [7:0]  low_int     = 8'h00;
  // Design and model outputs.
  tlr_req_t    req;
  logic        done;
  logic [7:0]  rdata;
  logic        crit;
  logic        alert;
  logic        tmo;
  logic [2:0]  code;
  int          n_errors    = 0;
  int          checked     = 0;

  // Clock of 40 ns.
  always #20 clk_i = ~clk_i;

  tlr_regs dut (
    .clk_i(clk_i), .srst_i(srst_i), .req_i(req), .rdata_o(rdata),
    .conv_done_i(conv_done), .local_temp_i(local_temp), .remote_temp_i(remote_temp),
    .remote_low_limit_int_i(low_int), .critical_temp_output_o(crit),
    .remote_low_alert_o(alert), .bus_timeout_enable_o(tmo), .consecutive_count_code_o(code)
  );

  tlr_host_model host (
    .clk_i(clk_i), .go_i(go), .op_i(op), .req_o(req), .done_o(done)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // One comparison; a mismatch is reported at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One access through the host model; the wait for completion is bounded.
  task automatic acc(input logic r, input logic w, input logic [7:0] p, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    go <= 1'b1;
    op <= '{rd: r, wr: w, ptr: p, wdata: d};
    @(posedge clk_i);
    go <= 1'b0;
    for (i = 0; i < 5; i++) begin
      @(posedge clk_i);
      #1;
      if (done === 1'b1) break;
    end
    if (i == 5) begin
      n_errors++;
      $display("wrong value at %0t: access never completed", $time);
      final_report();
    end
  endtask : acc

  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    acc(1'b1, 1'b0, p, 8'h00);
    chk(rdata, e, "register read");
  endtask : rd

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    acc(1'b0, 1'b1, p, d);
  endtask : wr

  // One conversion pulse; idle result lines show the inverse so stale data is never taken.
  task automatic conv(input logic [11:0] l, input logic [11:0] r);
    @(posedge clk_i);
    conv_done   <= 1'b1;
    local_temp  <= l;
    remote_temp <= r;
    @(posedge clk_i);
    conv_done   <= 1'b0;
    local_temp  <= ~l;
    remote_temp <= ~r;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : conv

  task automatic note(input string name);
    $display("test %s finished, %0d mismatches so far", name, n_errors);
  endtask : note

  // Reset values, including an unmapped pointer.
  task automatic t_reset();
    rd(`TLR_PTR_RLL_FRAC, 8'h00);
    rd(`TLR_PTR_LOCAL_FRAC, 8'h00);
    rd(`TLR_PTR_REMOTE_CRIT, 8'h6c);
    rd(`TLR_PTR_LOCAL_CRIT, 8'h55);
    rd(`TLR_PTR_CRIT_HYST, 8'h0a);
    rd(`TLR_PTR_ALERT_CFG, 8'h01);
    rd(8'h30, 8'h00);
    chk({7'h0, tmo}, 8'h00, "timeout enable after reset");
    note("reset");
  endtask : t_reset

  // Read-write registers, reserved bits and the read-only byte.
  task automatic t_regs();
    wr(`TLR_PTR_REMOTE_CRIT, 8'ha5);
    rd(`TLR_PTR_REMOTE_CRIT, 8'ha5);
    wr(`TLR_PTR_LOCAL_CRIT, 8'h3c);
    rd(`TLR_PTR_LOCAL_CRIT, 8'h3c);
    wr(`TLR_PTR_CRIT_HYST, 8'h07);
    rd(`TLR_PTR_CRIT_HYST, 8'h07);
    wr(`TLR_PTR_ALERT_CFG, 8'hff);
    rd(`TLR_PTR_ALERT_CFG, 8'h8f);
    chk({7'h0, tmo}, 8'h01, "timeout enable set");
    chk({5'h0, code}, 8'h07, "count code field");
    wr(`TLR_PTR_ALERT_CFG, 8'h00);
    rd(`TLR_PTR_ALERT_CFG, 8'h01);
    chk({7'h0, tmo}, 8'h00, "timeout enable clear");
    wr(`TLR_PTR_RLL_FRAC, 8'hff);
    rd(`TLR_PTR_RLL_FRAC, 8'hf0);
    wr(`TLR_PTR_LOCAL_FRAC, 8'hff);
    rd(`TLR_PTR_LOCAL_FRAC, 8'h00);
    note("registers");
  endtask : t_regs

  // The pair is read high byte first and also low byte first, with a conversion between the two reads.
  task automatic t_lock();
    // The earlier low-byte read left the high byte held; another access frees it.
    rd(`TLR_PTR_REMOTE_CRIT, 8'ha5);
    conv(12'h123, 12'h7f0);
    rd(`TLR_PTR_LOCAL_HI, 8'h12);
    conv(12'h456, 12'h7f0);
    rd(`TLR_PTR_LOCAL_FRAC, 8'h30);
    conv(12'h789, 12'h7f0);
    rd(`TLR_PTR_LOCAL_HI, 8'h78);
    rd(`TLR_PTR_LOCAL_FRAC, 8'h90);
    conv(12'habc, 12'h7f0);
    rd(`TLR_PTR_LOCAL_FRAC, 8'hc0);
    conv(12'hdef, 12'h7f0);
    rd(`TLR_PTR_LOCAL_HI, 8'hab);
    rd(`TLR_PTR_LOCAL_FRAC, 8'hf0);
    rd(`TLR_PTR_REMOTE_CRIT, 8'ha5);
    conv(12'h321, 12'h7f0);
    rd(`TLR_PTR_LOCAL_HI, 8'h32);
    note("pair lock");
  endtask : t_lock

  // Local limit 3Ch with hysteresis 7 releases at 35h; remote limit is A5h.
  task automatic t_crit();
    conv(12'h3b0, 12'h7f0);
    chk({7'h0, crit}, 8'h00, "below local limit");
    conv(12'h3c0, 12'h7f0);
    chk({7'h0, crit}, 8'h01, "at local limit");
    conv(12'h360, 12'h7f0);
    chk({7'h0, crit}, 8'h01, "inside hysteresis");
    conv(12'h350, 12'h7f0);
    chk({7'h0, crit}, 8'h00, "at release point");
    conv(12'h100, 12'ha50);
    chk({7'h0, crit}, 8'h01, "at remote limit");
    conv(12'h100, 12'h9e0);
    chk({7'h0, crit}, 8'h00, "remote release");
    note("critical output");
  endtask : t_crit

  // Combined low limit 208h, count codes 0, 1, 3 and 7.
  task automatic t_alert();
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    int         k;
    int         j;
    @(posedge clk_i);
    low_int <= 8'h20;
    wr(`TLR_PTR_RLL_FRAC, 8'h80);
    for (k = 0; k < 4; k++) begin
      wr(`TLR_PTR_ALERT_CFG, {4'h0, codes[k], 1'b0});
      chk({5'h0, code}, {5'h0, codes[k]}, "count code output");
      for (j = 0; j <= k; j++) begin
        conv(12'h100, 12'h207);
        chk({7'h0, alert}, {7'h0, (j == k)}, "alert after low readings");
      end
      conv(12'h100, 12'h208);
      chk({7'h0, alert}, 8'h00, "alert at combined limit");
    end
    note("consecutive alert");
  endtask : t_alert

  // Main sequence: ten cycles of reset, then every scenario.
  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_regs();
    t_lock();
    t_crit();
    t_alert();
    final_report();
  end

endmodule : tlr_regs_bench
`default_nettype wire
